/* hw/mdr_consts.svh */
`ifndef MDR_CONSTS_SVH
`define MDR_CONSTS_SVH

// register address map (upper bits pick the register kind)
`define MDR_KIND_INPUT     3'h0
`define MDR_KIND_GAIN      3'h1
`define MDR_KIND_OFFSET    3'h2
`define MDR_KIND_SPECIAL   3'h3
// special register indices within kind 3
`define MDR_SPC_GRP0_CODE   6'h00
`define MDR_SPC_GRP1_CODE   6'h01
`define MDR_SPC_GRP234_CODE 6'h02
`define MDR_SPC_CONTROL    6'h03
`define MDR_SPC_SEL_BASE   6'h08
`define MDR_SPC_STATUS     6'h10

// control bits
`define MDR_CTL_BANK       2
`define MDR_CTL_THERM      1
`define MDR_CTL_PDOWN      0

// reset values
`define MDR_RST_INPUT      14'h1555
`define MDR_RST_GAIN       14'h3fff
`define MDR_RST_OFFSET     14'h2000
`define MDR_RST_OFS        14'h1555
`define MDR_RST_CTL        3'h0
`define MDR_RST_SEL        8'h00

// arithmetic constants
`define MDR_HALF_SCALE     16'sh2000
`define MDR_FULL_SCALE     14'h3fff

`endif

/* hw/mdr_pkg.sv */
package mdr_pkg;
    typedef logic [13:0] mdr_code_t;
    typedef logic [8:0]  mdr_addr_t;
    typedef enum logic [1:0]
    {
        MDR_IDLE = 2'b00,
        MDR_CALC = 2'b01,
        MDR_LOAD = 2'b10
    } mdr_state_t;
endpackage

/* hw/mdr_cal_if.sv */
interface mdr_cal_if;
    logic [13:0] in_code;
    logic [13:0] gain;
    logic [13:0] offset;
    logic [13:0] result;

    modport master (output in_code, output gain, output offset, input result);
    modport unit   (input in_code, input gain, input offset, output result);
endinterface

/* hw/mdr_cal_unit.sv */
`include "mdr_consts.svh"

// shared trim multiplier and adder, one cycle of combinational logic
module mdr_cal_unit
(
    mdr_cal_if.unit cal
);
    import mdr_pkg::*;

    function automatic mdr_code_t mdr_clamp(input logic signed [16:0] v);
        if (v < 0)
            mdr_clamp = 14'h0000;
        else if (v > $signed({3'h0, `MDR_FULL_SCALE}))
            mdr_clamp = `MDR_FULL_SCALE;
        else
            mdr_clamp = v[13:0];
    endfunction

    logic [28:0]        product;
    logic signed [16:0] total;

    // x * (m + 1) / 2^14 + c - 2^13
    assign product = 29'(cal.in_code) * (29'(cal.gain) + 29'h1);
    assign total   = $signed({2'b00, product[28:14]})
                   + $signed({3'b000, cal.offset})
                   - 17'(`MDR_HALF_SCALE);
    assign cal.result = mdr_clamp(total);
endmodule // mdr_cal_unit

/* hw/mdr_register_bank.sv */
// What this block does
// - forty channels as five groups of eight
// - per channel 14-bit input registers A, B
// - per channel 14-bit gain trim register
// - per channel 14-bit offset trim register
// - hidden calibrated results A and B
// - converter code loads only from calibrated results
// - converter code is 14-bit output level
// - three group offset codes, last shared
// - control bit 2 picks input bank
// - control bit 1 enables thermal shutdown
// - control bit 0 selects soft power-down
// - per group 8-bit output bank select
// - channel writes recompute the matching calibrated bank
// - code = x*(m+1)/2^14 + c - 2^13
// - load strobe low updates all converter codes
`include "mdr_consts.svh"

module mdr_register_bank
#(
    parameter int GROUPS     = 5,
    parameter int PER_GROUP  = 8
)
(
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rst_n,
    // register port
    input  wire mdr_pkg::mdr_addr_t   reg_addr,
    input  wire logic [15:0]          reg_wdata,
    input  wire logic                 reg_write,
    input  wire logic                 reg_read,
    output logic [15:0]               reg_rdata,
    // load pin from outside
    input  wire logic                 load_all_outputs_n,
    // converter side
    output logic [GROUPS*PER_GROUP*14-1:0] dac_code,
    output logic                      thermal_shutdown_en,
    output logic                      soft_power_down,
    output logic                      cal_busy
);
    import mdr_pkg::*;

    localparam int CH = GROUPS * PER_GROUP;

    initial
    begin
        if (GROUPS != 5 || PER_GROUP != 8)
            $error("mdr_register_bank serves five groups of eight only");
    end

    ////////////////////////////////////////////////////////////////////////////
    // storage

    mdr_code_t  input_data_a [CH];
    mdr_code_t  input_data_b [CH];
    mdr_code_t  gain_trim    [CH];
    mdr_code_t  offset_trim  [CH];
    mdr_code_t  calibrated_a [CH];
    mdr_code_t  calibrated_b [CH];
    mdr_code_t  final_code   [CH];
    mdr_code_t  group0_offset_code;
    mdr_code_t  group1_offset_code;
    mdr_code_t  group234_offset_code;
    logic [2:0] control;
    logic [7:0] output_bank_select [GROUPS];

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    // addr = kind(3) : group(3) : channel(3)
    function automatic logic [5:0] mdr_chan(input mdr_addr_t a);
        mdr_chan = 6'(a[5:3] * 6'(PER_GROUP) + 6'(a[2:0]));
    endfunction

    function automatic logic mdr_chan_ok(input mdr_addr_t a);
        mdr_chan_ok = (a[8:6] <= `MDR_KIND_OFFSET) && (32'(a[5:3]) < GROUPS);
    endfunction

    logic [2:0] w_kind;
    logic [5:0] w_ch;
    logic [5:0] w_spc;
    logic       w_bank;

    assign w_kind = reg_addr[8:6];
    assign w_ch   = mdr_chan(reg_addr);
    assign w_spc  = reg_addr[5:0];
    assign w_bank = control[`MDR_CTL_BANK];

    ////////////////////////////////////////////////////////////////////////////
    // pin synchroniser

    logic load_meta;
    logic load_sync;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            load_meta <= 1'b1;
            load_sync <= 1'b1;
        end
        else
        begin
            load_meta <= load_all_outputs_n;
            load_sync <= load_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software writes to channel registers

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < CH; i++)
            begin
                input_data_a[i] <= `MDR_RST_INPUT;
                input_data_b[i] <= `MDR_RST_INPUT;
                gain_trim[i]    <= `MDR_RST_GAIN;
                offset_trim[i]  <= `MDR_RST_OFFSET;
            end
        end
        else if (reg_write && mdr_chan_ok(reg_addr))
        begin
            case (w_kind)
                `MDR_KIND_INPUT:
                begin
                    // global bank bit steers the data write
                    if (w_bank)
                        input_data_b[w_ch] <= reg_wdata[13:0];
                    else
                        input_data_a[w_ch] <= reg_wdata[13:0];
                end
                `MDR_KIND_GAIN:   gain_trim[w_ch]   <= reg_wdata[13:0];
                `MDR_KIND_OFFSET: offset_trim[w_ch] <= reg_wdata[13:0];
                default:          ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // global registers

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            group0_offset_code   <= `MDR_RST_OFS;
            group1_offset_code   <= `MDR_RST_OFS;
            group234_offset_code <= `MDR_RST_OFS;
            control              <= `MDR_RST_CTL;
            for (int g = 0; g < GROUPS; g++)
                output_bank_select[g] <= `MDR_RST_SEL;
        end
        else if (reg_write && w_kind == `MDR_KIND_SPECIAL)
        begin
            case (w_spc)
                `MDR_SPC_GRP0_CODE:   group0_offset_code   <= reg_wdata[13:0];
                `MDR_SPC_GRP1_CODE:   group1_offset_code   <= reg_wdata[13:0];
                `MDR_SPC_GRP234_CODE: group234_offset_code <= reg_wdata[13:0];
                `MDR_SPC_CONTROL: control              <= reg_wdata[2:0];
                default:
                begin
                    if (w_spc >= `MDR_SPC_SEL_BASE
                        && 32'(w_spc - `MDR_SPC_SEL_BASE) < GROUPS)
                        output_bank_select[3'(w_spc - `MDR_SPC_SEL_BASE)]
                            <= reg_wdata[7:0];
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            thermal_shutdown_en <= 1'b0;
            soft_power_down     <= 1'b0;
        end
        else
        begin
            thermal_shutdown_en <= control[`MDR_CTL_THERM];
            soft_power_down     <= control[`MDR_CTL_PDOWN];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // recompute sequencer: one shared trim unit, one channel at a time

    mdr_state_t state;
    logic [5:0] calc_ch;
    logic       calc_bank;
    logic       pend_load;

    mdr_cal_if cal ();

    mdr_cal_unit u_cal
    (
        .cal (cal)
    );

    // operands are read after the write has landed, hence one cycle later
    assign cal.in_code = calc_bank ? input_data_b[calc_ch] : input_data_a[calc_ch];
    assign cal.gain    = gain_trim[calc_ch];
    assign cal.offset  = offset_trim[calc_ch];

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            state     <= MDR_IDLE;
            calc_ch   <= 6'h00;
            calc_bank <= 1'b0;
        end
        else
        begin
            case (state)
                MDR_IDLE, MDR_CALC:
                begin
                    // any channel write recomputes the bank chosen by bit 2
                    if (reg_write && mdr_chan_ok(reg_addr))
                    begin
                        state     <= MDR_CALC;
                        calc_ch   <= w_ch;
                        calc_bank <= w_bank;
                    end
                    else
                        state <= MDR_IDLE;
                end
                default: state <= MDR_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < CH; i++)
            begin
                calibrated_a[i] <= `MDR_RST_INPUT;
                calibrated_b[i] <= `MDR_RST_INPUT;
            end
        end
        else if (state == MDR_CALC)
        begin
            if (calc_bank)
                calibrated_b[calc_ch] <= cal.result;
            else
                calibrated_a[calc_ch] <= cal.result;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // simultaneous load of converter codes

    // a low load level during a recompute waits so the fresh result is taken
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            pend_load <= 1'b0;
        else
            pend_load <= !load_sync && state == MDR_CALC;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < CH; i++)
                final_code[i] <= `MDR_RST_INPUT;
        end
        else if ((!load_sync && state != MDR_CALC) || pend_load)
        begin
            for (int i = 0; i < CH; i++)
                final_code[i] <= output_bank_select[i / PER_GROUP][i % PER_GROUP]
                               ? calibrated_b[i] : calibrated_a[i];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            dac_code <= '0;
            cal_busy <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < CH; i++)
                dac_code[i*14 +: 14] <= final_code[i];
            cal_busy <= state == MDR_CALC;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port: calibrated and converter registers are not reachable

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            reg_rdata <= 16'h0000;
        else if (reg_read)
        begin
            reg_rdata <= 16'h0000;
            case (reg_addr[8:6])
                `MDR_KIND_INPUT:
                    if (mdr_chan_ok(reg_addr))
                        reg_rdata <= {2'b00, w_bank ? input_data_b[w_ch] : input_data_a[w_ch]};
                `MDR_KIND_GAIN:
                    if (mdr_chan_ok(reg_addr))
                        reg_rdata <= {2'b00, gain_trim[w_ch]};
                `MDR_KIND_OFFSET:
                    if (mdr_chan_ok(reg_addr))
                        reg_rdata <= {2'b00, offset_trim[w_ch]};
                `MDR_KIND_SPECIAL:
                begin
                    if (w_spc == `MDR_SPC_GRP0_CODE)
                        reg_rdata <= {2'b00, group0_offset_code};
                    else if (w_spc == `MDR_SPC_GRP1_CODE)
                        reg_rdata <= {2'b00, group1_offset_code};
                    else if (w_spc == `MDR_SPC_GRP234_CODE)
                        reg_rdata <= {2'b00, group234_offset_code};
                    else if (w_spc == `MDR_SPC_CONTROL)
                        reg_rdata <= {13'h0000, control};
                    else if (w_spc == `MDR_SPC_STATUS)
                        reg_rdata <= {15'h0000, state == MDR_CALC};
                    else if (w_spc >= `MDR_SPC_SEL_BASE
                             && 32'(w_spc - `MDR_SPC_SEL_BASE) < GROUPS)
                        reg_rdata <= {8'h00,
                                      output_bank_select[3'(w_spc - `MDR_SPC_SEL_BASE)]};
                end
                default: reg_rdata <= 16'h0000;
            endcase
        end
    end
endmodule // mdr_register_bank

/* bench/mdr_register_bank_asserts.sv */
`include "mdr_consts.svh"

module mdr_bank_chk
#(
    parameter int GROUPS    = 5,
    parameter int PER_GROUP = 8
)
(
    // clock and reset
    input wire logic                           sys_clk,
    input wire logic                           rst_n,
    // register port
    input wire mdr_pkg::mdr_addr_t             reg_addr,
    input wire logic [15:0]                    reg_wdata,
    input wire logic                           reg_write,
    input wire logic                           reg_read,
    input wire logic [15:0]                    reg_rdata,
    // load pin and converter side
    input wire logic                           load_all_outputs_n,
    input wire logic [GROUPS*PER_GROUP*14-1:0] dac_code,
    input wire logic                           thermal_shutdown_en,
    input wire logic                           soft_power_down,
    input wire logic                           cal_busy
);
    import mdr_pkg::*;

    localparam mdr_addr_t CTL = {`MDR_KIND_SPECIAL, `MDR_SPC_CONTROL};
    logic [3:0] hi_cnt;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // cycles since the load pin was last low; margin covers sync and deferral
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || !load_all_outputs_n)
            hi_cnt <= 4'h0;
        else if (hi_cnt != 4'hf)
            hi_cnt <= hi_cnt + 4'h1;
    end

    ////////////////////////////////////////////////////////////////
    chk_unmapped_read: assert property (
        reg_read && reg_addr[8] |=> reg_rdata == 16'h0000)
        else $error("unmapped read returned data");
    // control lands one edge after the write, the outputs one edge after that
    chk_therm_bit: assert property (
        reg_write && reg_addr == CTL |=> ##1 thermal_shutdown_en == $past(reg_wdata[1], 2))
        else $error("thermal enable does not follow control bit 1");
    chk_pdown_bit: assert property (
        reg_write && reg_addr == CTL |=> ##1 soft_power_down == $past(reg_wdata[0], 2))
        else $error("power-down does not follow control bit 0");
    // strobes never coincide, so read data and outputs both carry pre-read control
    chk_ctl_readback: assert property (
        reg_read && reg_addr == CTL |=> reg_rdata[1:0] == {thermal_shutdown_en, soft_power_down})
        else $error("control readback differs from outputs");
    chk_dac_hold: assert property (hi_cnt >= 4'h8 |-> $stable(dac_code))
        else $error("converter codes changed without load");
    chk_busy_after_write: assert property (
        reg_write && reg_addr[8:6] <= 3'h2 && reg_addr[5:3] < 3'h5 |-> ##[1:3] cal_busy)
        else $error("no recompute after channel write");
    chk_busy_cause: assert property (
        cal_busy |-> $past(reg_write) || $past(reg_write, 2) || $past(reg_write, 3))
        else $error("recompute without a write");
    chk_reset_rdata: assert property (
        disable iff (1'b0) !rst_n |=> reg_rdata == 16'h0000)
        else $error("read data not cleared in reset");

    cover property (reg_write && reg_addr[8:6] == `MDR_KIND_INPUT);
    cover property ($fell(load_all_outputs_n));
    cover property (reg_read && reg_addr[8]);
endmodule // mdr_bank_chk

bind mdr_register_bank mdr_bank_chk #(.GROUPS(GROUPS), .PER_GROUP(PER_GROUP)) u_chk
(
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .load_all_outputs_n(load_all_outputs_n), .dac_code(dac_code),
    .thermal_shutdown_en(thermal_shutdown_en), .soft_power_down(soft_power_down),
    .cal_busy(cal_busy)
);

/* bench/mdr_register_bank_tb_top.sv */
`include "mdr_consts.svh"

module mdr_register_bank_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import mdr_pkg::*;

    logic         sys_clk;
    logic         rst_n;
    mdr_addr_t    reg_addr;
    logic [15:0]  reg_wdata;
    logic         reg_write;
    logic         reg_read;
    logic [15:0]  reg_rdata;
    logic         load_all_outputs_n;
    logic [559:0] dac_code;
    logic         thermal_shutdown_en;
    logic         soft_power_down;
    logic         cal_busy;
    int           fails;
    int           comparisons;
    int           seed;
    int           n;
    logic [15:0]  x, gain_v, offs_v;
    logic         b;
    mdr_code_t    exp_a [40];
    mdr_code_t    exp_b [40];
    logic [7:0]   sel [5];

    mdr_register_bank u_dut
    (
        .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .load_all_outputs_n(load_all_outputs_n), .dac_code(dac_code),
        .thermal_shutdown_en(thermal_shutdown_en), .soft_power_down(soft_power_down),
        .cal_busy(cal_busy)
    );

    ////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] e);
        comparisons++;
        if (seen !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", what, e, seen);
        end
    endtask

    task automatic wr(input mdr_addr_t a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input string what, input mdr_addr_t a, input logic [15:0] e);
        @(posedge sys_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1 check(what, reg_rdata, e);
    endtask

    function automatic mdr_addr_t sp(input logic [5:0] idx);
        return {`MDR_KIND_SPECIAL, idx};
    endfunction

    function automatic mdr_code_t cal(input int xi, input int mi, input int ci);
        int v;
        v = (xi * (mi + 1)) / 16384 + ci - 8192;
        return (v < 0) ? 14'h0000 : (v > 16383) ? 14'h3fff : v[13:0];
    endfunction

    // level load held long enough to pass the two-flop synchroniser
    task automatic load_all();
        @(posedge sys_clk);
        load_all_outputs_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        load_all_outputs_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
    endtask

    task automatic check_dacs();
        mdr_code_t e;
        for (int i = 0; i < 40; i++)
        begin
            e = sel[i/8][i%8] ? exp_b[i] : exp_a[i];
            check("dac_code", 16'(dac_code[i*14 +: 14]), 16'(e));
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    initial
    begin
        #400000;
        fails++;
        end_of_test();
    end

    initial
    begin
        seed = 32'hda79;
        rst_n = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        load_all_outputs_n = 1'b1;
        for (int i = 0; i < 40; i++)
        begin
            exp_a[i] = 14'h1555;
            exp_b[i] = 14'h1555;
        end
        sel = '{default: 8'h00};
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd("control", sp(`MDR_SPC_CONTROL), 16'h0000);
        check_dacs();
        for (int i = 0; i < 3; i++)
        begin
            x = 16'($random(seed)) & 16'h3fff;
            rd("group offset", sp(6'(i)), 16'h1555);
            wr(sp(6'(i)), x);
            rd("group offset", sp(6'(i)), x);
        end
        for (int v = 0; v < 8; v++)
        begin
            wr(sp(`MDR_SPC_CONTROL), 16'(v));
            rd("control", sp(`MDR_SPC_CONTROL), 16'(v));
            check("thermal", 16'(thermal_shutdown_en), 16'(v[1]));
            check("power down", 16'(soft_power_down), 16'(v[0]));
        end
        rd("unmapped", 9'h1ff, 16'h0000);
        rd("unmapped", sp(6'h3f), 16'h0000);
        rd("status", sp(`MDR_SPC_STATUS), 16'h0000);
        // random channel traffic, corners at two fixed steps
        for (int i = 0; i < 24; i++)
        begin
            b = i[0];
            n = ($random(seed) & 32'h7fffffff) % 40;
            x = 16'($random(seed)) & 16'h3fff;
            gain_v = 16'($random(seed)) & 16'h3fff;
            offs_v = 16'($random(seed)) & 16'h3fff;
            if (i == 2)
                {x, gain_v, offs_v} = {3{16'h3fff}};
            if (i == 3)
                {x, gain_v, offs_v} = '0;
            wr(sp(`MDR_SPC_CONTROL), {13'h0, b, 2'b00});
            wr({`MDR_KIND_INPUT, 3'(n / 8), 3'(n % 8)}, x);
            wr({`MDR_KIND_GAIN, 3'(n / 8), 3'(n % 8)}, gain_v);
            wr({`MDR_KIND_OFFSET, 3'(n / 8), 3'(n % 8)}, offs_v);
            // busy stands in the cycle after the recompute edge
            @(posedge sys_clk);
            #1 check("busy", 16'(cal_busy), 16'h0001);
            rd("input", {`MDR_KIND_INPUT, 3'(n / 8), 3'(n % 8)}, x);
            rd("gain", {`MDR_KIND_GAIN, 3'(n / 8), 3'(n % 8)}, gain_v);
            rd("offset", {`MDR_KIND_OFFSET, 3'(n / 8), 3'(n % 8)}, offs_v);
            wr(sp(`MDR_SPC_SEL_BASE + 6'(n / 8)), 16'($random(seed)) & 16'h00ff);
            rd("select", sp(`MDR_SPC_SEL_BASE + 6'(n / 8)), reg_wdata);
            check_dacs();
            sel[n/8] = reg_wdata[7:0];
            if (b)
                exp_b[n] = cal(x, gain_v, offs_v);
            else
                exp_a[n] = cal(x, gain_v, offs_v);
            load_all();
            check_dacs();
        end
        end_of_test();
    end
endmodule // mdr_register_bank_tb_top
